/* File: src/ecrc_ctrl.sv */
// controller outside the endpoint: clock select, board reset, link reset handshake
// assumes endpoint status pins arrive asynchronously; mclk 20 MHz
`timescale 1ns/10ps
`default_nettype none
`include "ecrc_params.svh"
module ecrc_ctrl (
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   input  wire logic [2:0]            lane_cnt,       // built lanes: 1, 2 or 4
   input  wire logic                  unified,        // unified clock option
   input  wire logic                  user_reset_req, // pulse: reset link partner
   input  wire logic                  trained_down,   // async: link runs one lane
   input  wire logic                  port_trained,   // async: port initialised
   input  wire logic                  partner_rst_rcvd, // async: reset from partner
   output var  logic                  board_reset,
   output var  logic                  partner_rst_req,
   output var  logic                  app_reset,
   output var  ecrc_pkg::ecrc_clksel_t clk_sel,
   output var  logic                  log_follows_core,
   output var  logic                  busy
);
   localparam logic [4:0] HOLD_CYC = 5'(`ECRC_RST_HOLD_CYC);
   localparam logic [4:0] INIT_CYC = 5'(`ECRC_RST_HOLD_CYC + 1);

   logic td_s, pt_s, rr_s;
   logic td_prev_q;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic       init_q;
   ecrc_pkg::ecrc_state_t st_q, st_d;
   ecrc_pkg::ecrc_clksel_t sel_d;

   // ==========================================================================
   // synchronise endpoint status pins
   ecrc_sync3 u_sync_td (.mclk(mclk), .nrst(nrst), .din(trained_down), .dout(td_s));
   ecrc_sync3 u_sync_pt (.mclk(mclk), .nrst(nrst), .din(port_trained), .dout(pt_s));
   ecrc_sync3 u_sync_rr (.mclk(mclk), .nrst(nrst), .din(partner_rst_rcvd), .dout(rr_s));

   // ==========================================================================
   // clock select: only divides of the one user clock move; refclk is fixed at build
   always_comb begin
      sel_d.pcs_div = 2'(`ECRC_PCS_DIV);
      sel_d.narrow  = (lane_cnt != 3'h1) && td_s;
      if (lane_cnt == 3'h1 || sel_d.narrow) begin
         sel_d.core_div = 3'(`ECRC_NARROW_DIV);
      end else if (lane_cnt == 3'h2) begin
         sel_d.core_div = 3'(`ECRC_WIDE_DIV_2X);
      end else begin
         sel_d.core_div = 3'(`ECRC_WIDE_DIV_4X);
      end
   end
   // registered select and unified tie-off
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         clk_sel          <= '{narrow: 1'b0, core_div: 3'h4, pcs_div: 2'h2};
         log_follows_core <= 1'b0;
         td_prev_q        <= 1'b0;
      end else begin
         clk_sel          <= sel_d;
         log_follows_core <= unified;
         // a rate change seen mid-hold stays pending and earns its own hold
         if (st_q == ecrc_pkg::ECRC_IDLE) begin
            td_prev_q     <= td_s;
         end
      end
   end

   // ==========================================================================
   // handshake state machine
   always_comb begin
      st_d  = st_q;
      cnt_d = (cnt_q != 5'h0) ? cnt_q - 5'h1 : 5'h0;
      case (st_q)
         ecrc_pkg::ECRC_IDLE: begin
            if (rr_s) begin
               st_d  = ecrc_pkg::ECRC_BRST;
               cnt_d = HOLD_CYC;
            end else if (td_s != td_prev_q) begin
               st_d  = ecrc_pkg::ECRC_BRST;
               cnt_d = HOLD_CYC;
            end else if (user_reset_req) begin
               st_d  = pt_s ? ecrc_pkg::ECRC_WAITLO : ecrc_pkg::ECRC_BRST;
               cnt_d = HOLD_CYC;
            end
         end
         ecrc_pkg::ECRC_WAITLO: begin
            if (!pt_s) begin
               st_d  = ecrc_pkg::ECRC_BRST;
               cnt_d = HOLD_CYC;
            end
         end
         ecrc_pkg::ECRC_BRST: begin
            if (cnt_q == 5'h1) begin
               st_d = ecrc_pkg::ECRC_SETTLE;
            end
         end
         ecrc_pkg::ECRC_SETTLE: begin
            if (!rr_s) begin
               st_d = ecrc_pkg::ECRC_IDLE;             // avoid re-looping on a held flag
            end
         end
         default: begin
            st_d = ecrc_pkg::ECRC_IDLE;
         end
      endcase
   end
   // state, counter, power-on reset
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q   <= ecrc_pkg::ECRC_IDLE;
         cnt_q  <= INIT_CYC;
         init_q <= 1'b1;
      end else if (init_q) begin
         cnt_q  <= cnt_q - 5'h1;
         init_q <= (cnt_q != 5'h1);
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end
   // outputs, all registered; board reset stays on across the whole hold
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         board_reset     <= 1'b1;
         partner_rst_req <= 1'b0;
         app_reset       <= 1'b1;
         busy            <= 1'b1;
      end else begin
         board_reset     <= init_q || st_d == ecrc_pkg::ECRC_BRST;
         partner_rst_req <= !init_q && st_d == ecrc_pkg::ECRC_WAITLO;
         app_reset       <= init_q || (st_d == ecrc_pkg::ECRC_BRST && rr_s);
         busy            <= init_q || st_d != ecrc_pkg::ECRC_IDLE;
      end
   end

   // ==========================================================================
   // checks
   sequence s_trained_fall;
      (!init_q && st_q == ecrc_pkg::ECRC_WAITLO) ##1 !pt_s;
   endsequence
   chk_req_hold_low : assert property (@(posedge mclk) disable iff (!nrst)
      (st_q == ecrc_pkg::ECRC_WAITLO && pt_s) |=> partner_rst_req)
      else $error("partner request dropped before trained fell");
   chk_handshake_brst : assert property (@(posedge mclk) disable iff (!nrst)
      s_trained_fall |-> ##1 board_reset)
      else $error("board reset missing after trained fell");
   chk_rst_min_width : assert property (@(posedge mclk) disable iff (!nrst)
      $rose(board_reset) |-> board_reset [*4])
      else $error("board reset shorter than minimum");
   chk_partner_rst : assert property (@(posedge mclk) disable iff (!nrst)
      (!init_q && st_q == ecrc_pkg::ECRC_IDLE && rr_s) |-> ##1 board_reset && app_reset)
      else $error("partner reset not answered");
   chk_traindown_rst : assert property (@(posedge mclk) disable iff (!nrst)
      (!init_q && st_q == ecrc_pkg::ECRC_IDLE && !rr_s && td_s != td_prev_q) |-> ##1 board_reset)
      else $error("rate switch without reset");
   chk_narrow_div : assert property (@(posedge mclk) disable iff (!nrst)
      (lane_cnt != 3'h1 && td_s) |=> clk_sel.core_div == 3'h4 && clk_sel.narrow)
      else $error("traindown rate not selected");
   chk_single_lane : assert property (@(posedge mclk) disable iff (!nrst)
      (lane_cnt == 3'h1) |=> !clk_sel.narrow && clk_sel.core_div == 3'h4)
      else $error("single lane must not select");
   chk_pcs_half : assert property (@(posedge mclk) disable iff (!nrst)
      (lane_cnt == 3'h2 && !td_s) |=> clk_sel.pcs_div == 2'h2 && clk_sel.core_div == 3'h2)
      else $error("two-lane divide wrong");
   chk_unified_tie : assert property (@(posedge mclk) disable iff (!nrst)
      unified |=> log_follows_core)
      else $error("unified tie not applied");
   chk_init_reset : assert property (@(posedge mclk) disable iff (!nrst)
      $rose(nrst) |-> board_reset)
      else $error("no initial reset");
endmodule // ecrc_ctrl
`default_nettype wire

/* File: src/ecrc_params.svh */
// constants for the endpoint clock/reset controller
// assumes a 20 MHz mclk; included by bare name
`ifndef ECRC_PARAMS_SVH
`define ECRC_PARAMS_SVH
// ==========================================================================
// timing
`define ECRC_MCLK_NS          50
`define ECRC_RST_MIN_CYC      4
// minimum board reset hold in ns (four slowest domain cycles at 15.63 MHz, rounded up)
`define ECRC_RST_HOLD_NS      256
`define ECRC_RST_HOLD_CYC     ((`ECRC_RST_HOLD_NS + `ECRC_MCLK_NS - 1) / `ECRC_MCLK_NS)
// clock divide ratios against the transceiver user clock
`define ECRC_PCS_DIV          2
`define ECRC_WIDE_DIV_2X      2
`define ECRC_WIDE_DIV_4X      1
`define ECRC_NARROW_DIV       4
`define ECRC_LINK_TIMEOUT_CYC 16'h0400
`endif

/* File: src/ecrc_pkg.sv */
// types for the endpoint clock/reset controller
// assumes ecrc_params.svh is not needed here
package ecrc_pkg;
   // ==========================================================================
   // controller states
   typedef enum logic [2:0] {
      ECRC_IDLE    = 3'b000,
      ECRC_REQ     = 3'b001,
      ECRC_WAITLO  = 3'b010,
      ECRC_BRST    = 3'b011,
      ECRC_SETTLE  = 3'b100
   } ecrc_state_t;
   // clock-select bundle to the clock source
   typedef struct packed {
      logic       narrow;   // trained-down rate selected
      logic [2:0] core_div; // core clock divide of user clock
      logic [1:0] pcs_div;  // pcs clock divide of user clock
   } ecrc_clksel_t;
endpackage

/* File: src/ecrc_sync3.sv */
// three-flop input synchroniser, change accepted when flops 2 and 3 agree
// assumes one clock mclk and synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module ecrc_sync3 (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic din,
   output var  logic dout
);
   logic [2:0] s_q;
   // ==========================================================================
   // shift chain; first flop feeds only the second
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q <= 3'h0;
      end else begin
         s_q <= {s_q[1:0], din};
      end
   end
   // accept only a stable level
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dout <= 1'b0;
      end else if (s_q[1] == s_q[2]) begin
         dout <= s_q[2];
      end
   end
endmodule // ecrc_sync3
`default_nettype wire

/* File: test/ecrc_endpoint_model.sv */
// behavioural model of the endpoint seen from the controller's side
// assumes one model clock shared with the controller (mclk)
`timescale 1ns/10ps
`default_nettype none
module ecrc_endpoint_model #(
   parameter int DROP_DLY = 3
) (
   input  wire logic mclk,
   input  wire logic board_reset,
   input  wire logic partner_rst_req,
   input  wire logic peer_reset,
   input  wire logic go_narrow,
   output var  logic port_trained,
   output var  logic partner_rst_rcvd,
   output var  logic trained_down
);
   int rst_cnt = 4;
   int req_cnt = 0;
   initial begin
      port_trained = 1'b0;
      partner_rst_rcvd = 1'b0;
      trained_down = 1'b0;
   end
   // ======================================================================
   // board reset stretched by four cycles; all domains share one clock here
   always @(posedge mclk) begin
      rst_cnt <= board_reset ? 4 : (rst_cnt > 0 ? rst_cnt - 1 : 0);
   end
   // training drops a few cycles into a request, so the handshake overlaps
   always @(posedge mclk) begin
      req_cnt <= partner_rst_req ? req_cnt + 1 : 0;
      port_trained <= (rst_cnt == 0) && !board_reset && (req_cnt < DROP_DLY);
   end
   // partner reset flag held until the board reset answers it
   always @(posedge mclk) begin
      partner_rst_rcvd <= peer_reset | (partner_rst_rcvd & ~board_reset);
      trained_down <= go_narrow;
   end
endmodule // ecrc_endpoint_model
`default_nettype wire

/* File: test/tb_endpoint_clock_reset_control.sv */
// self-checking bench for the endpoint clock/reset controller
// assumes ecrc_pkg, ecrc_ctrl and ecrc_endpoint_model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "ecrc_params.svh"
module tb_endpoint_clock_reset_control;
   logic                   mclk = 1'b0;
   logic                   nrst = 1'b0;
   logic [2:0]             lane_cnt = 3'h4;
   logic                   unified = 1'b0;
   logic                   user_reset_req = 1'b0;
   logic                   peer_reset = 1'b0;
   logic                   go_narrow = 1'b0;
   logic                   trained_down, port_trained, partner_rst_rcvd;
   logic                   board_reset, partner_rst_req, app_reset, log_follows_core, busy;
   ecrc_pkg::ecrc_clksel_t clk_sel;
   int                     err_count = 0;
   int                     comparisons = 0;
   int                     cycles = 0;
   int                     n;
   ecrc_ctrl uut (.mclk(mclk), .nrst(nrst), .lane_cnt(lane_cnt), .unified(unified),
      .user_reset_req(user_reset_req), .trained_down(trained_down),
      .port_trained(port_trained), .partner_rst_rcvd(partner_rst_rcvd),
      .board_reset(board_reset), .partner_rst_req(partner_rst_req), .app_reset(app_reset),
      .clk_sel(clk_sel), .log_follows_core(log_follows_core), .busy(busy));
   ecrc_endpoint_model ep (.mclk(mclk), .board_reset(board_reset),
      .partner_rst_req(partner_rst_req), .peer_reset(peer_reset), .go_narrow(go_narrow),
      .port_trained(port_trained), .partner_rst_rcvd(partner_rst_rcvd),
      .trained_down(trained_down));
   // ======================================================================
   // clock and hang guard; a full run needs well under a thousand cycles
   initial begin
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ======================================================================
   // shared helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   function automatic logic pick(input int w);
      return (w == 0) ? board_reset : (w == 1) ? busy : (w == 2) ? partner_rst_req : port_trained;
   endfunction
   // bounded wait; n keeps the cycle count, so it doubles as a width gauge
   task automatic wait_on(input int w, input logic v);
      n = 0;
      while (pick(w) !== v && n < 40) begin
         step(1);
         n++;
      end
      chk({7'h0, n < 40}, 8'h1);
   endtask
   task automatic pulse_width();
      wait_on(0, 1'b0);
      chk({7'h0, n >= `ECRC_RST_MIN_CYC}, 8'h1);
      wait_on(1, 1'b0);
   endtask
   // ======================================================================
   // scenarios
   task automatic t_reset(input logic [2:0] lanes, input logic uni);
      nrst = 1'b0;
      lane_cnt = lanes;
      unified = uni;
      step(5);
      chk({6'h0, board_reset, app_reset}, 8'h3);
      chk({6'h0, busy, partner_rst_req}, 8'h2);
      nrst = 1'b1;
      pulse_width();
      chk({5'h0, clk_sel.core_div}, 8'(4 / lanes));
      chk({6'h0, clk_sel.pcs_div}, 8'h2);
      chk({7'h0, log_follows_core}, {7'h0, uni});
      $display("test reset lanes=%0d done", lanes);
   endtask
   task automatic t_user();
      // link must be up and past the pin synchroniser, else the request skips the handshake
      wait_on(3, 1'b1);
      step(5);
      user_reset_req = 1'b1;
      step(1);
      user_reset_req = 1'b0;
      wait_on(2, 1'b1);
      // request must stay up while training lasts; board reset only after it drops
      while (board_reset !== 1'b1 && n < 40) begin
         if (port_trained === 1'b1) chk({7'h0, partner_rst_req}, 8'h1);
         step(1);
         n++;
      end
      chk({6'h0, board_reset, port_trained}, 8'h2);
      pulse_width();
      $display("test user link reset done");
   endtask
   task automatic t_partner();
      peer_reset = 1'b1;
      step(1);
      peer_reset = 1'b0;
      wait_on(0, 1'b1);
      chk({6'h0, board_reset, app_reset}, 8'h3);
      pulse_width();
      chk({7'h0, partner_rst_rcvd}, 8'h0);
      $display("test partner reset done");
   endtask
   task automatic t_narrow(input logic down, input logic [7:0] exp);
      go_narrow = down;
      wait_on(0, 1'b1);
      pulse_width();
      chk({clk_sel.narrow, 4'h0, clk_sel.core_div}, exp);
      $display("test rate switch down=%0d done", down);
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      t_reset(3'h2, 1'b1);
      t_reset(3'h1, 1'b1);
      t_reset(3'h4, 1'b0);
      t_user();
      t_partner();
      t_narrow(1'b1, 8'h84);
      t_narrow(1'b0, 8'h01);
      report_and_stop();
   end
endmodule // tb_endpoint_clock_reset_control
`default_nettype wire
